// *** hw/tmc_timer.v ***
`timescale 1ns/1ps
`default_nettype none

`include "tmc_defines.vh"

// Overview of operation
// - 16-bit count in two bytes, wraps upward
// - Wrap from all ones sets latched overflow flag
// - Interrupt passes only while enable bit set
// - Source select picks pin edges or Fosc/4
// - Run control starts and stops counting
// - Prescale field divides by 1, 2, 4, 8
// - Oscillator enable runs or shuts off oscillator
// - Sync bit used only with external clock
// - Counter uses oscillator pin when oscillator on and external clock selected
// - Oscillator on forces both pins to inputs
// - Synchroniser sits after ripple prescaler
// - Sleep holds synced count, prescaler still runs
// - Synchroniser samples on phases two and four
// - Synced count updates after sampler sees edge
// - Unsynced mode counts in sleep, may wake
// - Unsynced count is no capture/compare time base
// - Internal reset input from compare clears count
// - Control bits seven and six read zero
// - Write to either count byte clears prescaler
// - Trigger reset sets no flag; write wins
// - Power-on reset clears control to zero
module tmc_timer (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Timer pins
    input wire ext_clock_pin,
    input wire osc_input_pin,
    input wire [1:0] port_direction,
    output reg [1:0] pin_dir_eff,
    output reg osc_amp_enable,
    // Processor and capture/compare side
    input wire sleep_mode,
    input wire ccp_reset_trigger,
    output reg overflow_irq,
    output reg [15:0] time_base,
    output reg time_base_valid
);

    // Software-visible state
    reg [7:0] timer_control;
    reg [7:0] count_low_byte;
    reg [7:0] count_high_byte;
    reg overflow_flag;
    reg overflow_irq_enable;

    // Instruction cycle phase counter
    reg [1:0] q_phase;

    // Pin synchronisers and glitch filter
    wire [`TMC_NUM_PINS-1:0] pin_in;
    reg [`TMC_NUM_PINS-1:0] pin_s1;
    reg [`TMC_NUM_PINS-1:0] pin_s2;
    reg [`TMC_NUM_PINS-1:0] pin_s3;
    reg [`TMC_NUM_PINS-1:0] pin_level;

    // Prescaler and count path
    reg src_level_d;
    reg [2:0] pre_cnt;
    reg pre_out;
    reg pre_out_d;
    reg pre_sample;
    reg [7:0] next_rdata;

    // Control fields
    wire run_control;
    wire clock_source_select;
    wire sync_disable;
    wire osc_enable;
    wire [1:0] prescale_select;

    // Decoded events
    wire [15:0] count;
    wire src_level;
    wire src_rise;
    wire async_mode;
    wire sample_now;
    wire sync_rise;
    wire async_rise;
    wire count_inc;
    wire wr_cnt_lo;
    wire wr_cnt_hi;
    wire wr_count;
    wire wr_flag;
    wire wr_enable;
    wire wr_ctrl;
    wire ovf_set;

    assign run_control = timer_control[`TMC_BIT_RUN];
    assign clock_source_select = timer_control[`TMC_BIT_CS];
    assign sync_disable = timer_control[`TMC_BIT_NOSYNC];
    assign osc_enable = timer_control[`TMC_BIT_OSCEN];
    assign prescale_select = timer_control[`TMC_PS_HI:`TMC_PS_LO];

    assign count = {count_high_byte, count_low_byte};

    assign wr_cnt_lo = reg_wr && (reg_addr == `TMC_ADDR_CNT_LO);
    assign wr_cnt_hi = reg_wr && (reg_addr == `TMC_ADDR_CNT_HI);
    assign wr_count = wr_cnt_lo || wr_cnt_hi;
    assign wr_flag = reg_wr && (reg_addr == `TMC_ADDR_FLAG);
    assign wr_enable = reg_wr && (reg_addr == `TMC_ADDR_ENABLE);
    assign wr_ctrl = reg_wr && (reg_addr == `TMC_ADDR_CTRL);

    // Oscillator runs at sys_clk; the instruction clock is a quarter of
    // it. The phase counter freezes in sleep, which stops timer mode;
    // the sampler is held off in sleep by its own sleep gate.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_phase <= `TMC_Q1;
        end else if (!sleep_mode) begin
            q_phase <= q_phase + `TMC_Q_STEP;
        end
    end

    // Both timer pins pass three flops; a level is accepted only when
    // the second and third agree, so a single-cycle glitch is dropped.
    assign pin_in[`TMC_PIN_EXT] = ext_clock_pin;
    assign pin_in[`TMC_PIN_OSC] = osc_input_pin;

    genvar gi;
    generate
        for (gi = 0; gi < `TMC_NUM_PINS; gi = gi + 1) begin : g_pin
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    pin_s3[gi] <= 1'b0;
                    pin_level[gi] <= 1'b0;
                end else begin
                    pin_s1[gi] <= pin_in[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi]) begin
                        pin_level[gi] <= pin_s3[gi];
                    end
                end
            end
        end
    endgenerate

    // Counter source: oscillator pin while the oscillator is on, else
    // the dedicated clock pin; timer mode uses the instruction clock.
    assign src_level = clock_source_select ?
        (osc_enable ? pin_level[`TMC_PIN_OSC]
                    : pin_level[`TMC_PIN_EXT]) :
        q_phase[1];
    assign src_rise = src_level && !src_level_d;

    // Ripple-style prescaler, clocked by input rising edges. It keeps
    // running in sleep on external edges, and any count write clears it.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_level_d <= 1'b0;
            pre_cnt <= `TMC_PRE_ZERO;
        end else begin
            src_level_d <= src_level;
            if (wr_count) begin
                pre_cnt <= `TMC_PRE_ZERO;
            end else if (src_rise) begin
                pre_cnt <= pre_cnt + `TMC_PRE_ONE;
            end
        end
    end

    // Prescaler output: the source itself at 1:1, else the symmetric counter bit for the chosen ratio
    always @* begin
        case (prescale_select)
            `TMC_PS_DIV1: pre_out = src_level;
            `TMC_PS_DIV2: pre_out = pre_cnt[0];
            `TMC_PS_DIV4: pre_out = pre_cnt[1];
            `TMC_PS_DIV8: pre_out = pre_cnt[2];
            default: pre_out = src_level;
        endcase
    end

    // The sync bit matters only with the external clock selected
    assign async_mode = clock_source_select && sync_disable;

    // Sampler after the prescaler, on phases two and four only, and off
    // in sleep; the count moves only once a sample sees the rise.
    assign sample_now = !sleep_mode &&
        ((q_phase == `TMC_Q2) || (q_phase == `TMC_Q4));
    assign sync_rise = sample_now && pre_out && !pre_sample;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_sample <= 1'b0;
            pre_out_d <= 1'b0;
        end else begin
            pre_out_d <= pre_out;
            if (wr_count) begin
                pre_sample <= 1'b0;
            end else if (sample_now) begin
                pre_sample <= pre_out;
            end
        end
    end

    // Unsynchronised mode ignores phases and sleep alike
    assign async_rise = pre_out && !pre_out_d;

    assign count_inc = run_control &&
        (async_mode ? async_rise : sync_rise);

    // Wrap sets the flag; a trigger clear or a count write never does
    assign ovf_set = count_inc && (count == `TMC_COUNT_MAX) &&
        !wr_count && !ccp_reset_trigger;

    // Count bytes. A software write beats the compare trigger, which
    // beats an increment. Power-on reset and the trigger both zero the count; the
    // trigger is honoured in async mode too, where it may race edges.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_low_byte <= `TMC_BYTE_ZERO;
            count_high_byte <= `TMC_BYTE_ZERO;
        end else if (wr_count) begin
            if (wr_cnt_lo) begin
                count_low_byte <= reg_wdata;
            end
            if (wr_cnt_hi) begin
                count_high_byte <= reg_wdata;
            end
        end else if (ccp_reset_trigger) begin
            count_low_byte <= `TMC_BYTE_ZERO;
            count_high_byte <= `TMC_BYTE_ZERO;
        end else if (count_inc) begin
            {count_high_byte, count_low_byte} <=
                count + `TMC_COUNT_ONE;
        end
    end

    // Control register is cleared only by power-on or brown-out reset
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_control <= `TMC_CTRL_RESET;
        end else if (wr_ctrl) begin
            timer_control <= reg_wdata & `TMC_CTRL_MASK;
        end
    end

    // Overflow flag: hardware set wins over a software clear
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
        end else if (ovf_set) begin
            overflow_flag <= 1'b1;
        end else if (wr_flag) begin
            overflow_flag <= reg_wdata[`TMC_BIT_OVF];
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_irq_enable <= 1'b0;
        end else if (wr_enable) begin
            overflow_irq_enable <= reg_wdata[`TMC_BIT_OVF_EN];
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always @* begin
        next_rdata = `TMC_BYTE_ZERO;
        case (reg_addr)
            `TMC_ADDR_CNT_LO: next_rdata = count_low_byte;
            `TMC_ADDR_CNT_HI: next_rdata = count_high_byte;
            `TMC_ADDR_CTRL: next_rdata = timer_control & `TMC_CTRL_MASK;
            `TMC_ADDR_FLAG: next_rdata[`TMC_BIT_OVF] = overflow_flag;
            `TMC_ADDR_ENABLE:
                next_rdata[`TMC_BIT_OVF_EN] = overflow_irq_enable;
            default: next_rdata = `TMC_BYTE_ZERO;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `TMC_BYTE_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= `TMC_BYTE_ZERO;
        end
    end

    // Registered outputs toward pins, interrupt logic and compare units
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_dir_eff <= `TMC_DIR_RESET;
            osc_amp_enable <= 1'b0;
            overflow_irq <= 1'b0;
            time_base <= `TMC_COUNT_RESET;
            time_base_valid <= 1'b0;
        end else begin
            // Oscillator pins become inputs whatever direction is set
            pin_dir_eff <= osc_enable ? `TMC_DIR_INPUT
                                      : port_direction;
            // Amplifier and feedback are off when clear, saving power
            osc_amp_enable <= osc_enable;
            // Stays live in sleep so async overflow can wake the core
            overflow_irq <= overflow_flag &&
                overflow_irq_enable;
            time_base <= count;
            time_base_valid <= !async_mode;
        end
    end

endmodule

`default_nettype wire

// *** hw/tmc_defines.vh ***
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// Register offsets on the plain register port
`define TMC_ADDR_FLAG 8'h0c
`define TMC_ADDR_CNT_LO 8'h0e
`define TMC_ADDR_CNT_HI 8'h0f
`define TMC_ADDR_CTRL 8'h10
`define TMC_ADDR_ENABLE 8'h8c

// Control register layout
`define TMC_CTRL_RESET 8'h00
`define TMC_CTRL_MASK 8'h3f
`define TMC_BIT_RUN 0
`define TMC_BIT_CS 1
`define TMC_BIT_NOSYNC 2
`define TMC_BIT_OSCEN 3
`define TMC_PS_LO 4
`define TMC_PS_HI 5

// Prescale codes
`define TMC_PS_DIV1 2'h0
`define TMC_PS_DIV2 2'h1
`define TMC_PS_DIV4 2'h2
`define TMC_PS_DIV8 2'h3

// Flag and enable bits
`define TMC_BIT_OVF 0
`define TMC_BIT_OVF_EN 0

// Values
`define TMC_BYTE_ZERO 8'h00
`define TMC_COUNT_RESET 16'h0000
`define TMC_COUNT_MAX 16'hffff
`define TMC_COUNT_ONE 16'h0001
`define TMC_PRE_ZERO 3'h0
`define TMC_PRE_ONE 3'h1
`define TMC_DIR_INPUT 2'h3
`define TMC_DIR_RESET 2'h3
`define TMC_SYNC_RESET 2'h0

// Instruction cycle phases, one per oscillator period
`define TMC_Q1 2'h0
`define TMC_Q2 2'h1
`define TMC_Q3 2'h2
`define TMC_Q4 2'h3
`define TMC_Q_STEP 2'h1

// Pin index inside the input synchronisers
`define TMC_PIN_EXT 0
`define TMC_PIN_OSC 1
`define TMC_NUM_PINS 2

`endif

// *** verification/tmc_ext_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmc_ext_source (
    // Burst control
    input wire logic src_en,
    // Source pins
    output logic ext_clock_pin,
    output logic osc_input_pin
);
    // Pins rest low between bursts; the two rates differ so a wrong
    // pin choice gives a different count
    initial ext_clock_pin = 1'b0;
    initial osc_input_pin = 1'b0;
    always #110 ext_clock_pin = src_en & ~ext_clock_pin;
    always #170 osc_input_pin = src_en & ~osc_input_pin;
endmodule
`default_nettype wire

// *** verification/tmc_timer_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_checker (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Timer side
    input wire [1:0] pin_dir_eff,
    input wire osc_amp_enable,
    input wire ccp_reset_trigger,
    input wire overflow_irq,
    input wire [15:0] time_base,
    input wire time_base_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_ctrl_wr;
        reg_wr && reg_addr == 8'h10 ##1 !reg_wr;
    endsequence
    sequence s_stop;
        reg_wr && reg_addr == 8'h10 && !reg_wdata[0];
    endsequence
    chk_ctrl_top_zero: assert property (
        reg_rd && reg_addr == 8'h10 |=> reg_rdata[7:6] == 2'b00)
        else $error("control top bits not zero");
    chk_osc_amp_follow: assert property (
        s_ctrl_wr |=> osc_amp_enable == $past(reg_wdata[3], 2))
        else $error("oscillator enable wrong");
    chk_pin_dir_forced: assert property (
        s_ctrl_wr |=> !$past(reg_wdata[3], 2) || pin_dir_eff == 2'b11)
        else $error("pins not forced to inputs");
    chk_base_valid_mode: assert property (
        s_ctrl_wr |=> time_base_valid ==
        !($past(reg_wdata[1], 2) && $past(reg_wdata[2], 2)))
        else $error("time base valid wrong");
    // The time base lags the count by a cycle, so its cause is two back
    chk_count_step: assert property (
        $changed(time_base) && !$past(reg_wr, 2) &&
        !$past(ccp_reset_trigger, 2)
        |-> time_base == $past(time_base) + 16'h0001)
        else $error("count step not one");
    chk_irq_latched: assert property (
        overflow_irq && !reg_wr && !$past(reg_wr) |=> overflow_irq)
        else $error("overflow not latched");
    chk_irq_masked: assert property (
        reg_wr && reg_addr == 8'h8c && !reg_wdata[0] |=> ##1 !overflow_irq)
        else $error("masked interrupt passed");
    chk_trigger_clear: assert property (
        ccp_reset_trigger && !reg_wr |=> ##1 time_base == 16'h0000)
        else $error("trigger did not clear count");
    chk_stop_holds: assert property (
        s_stop ##1 (!reg_wr && !ccp_reset_trigger) [*3]
        |=> $stable(time_base))
        else $error("stopped count moved");
endmodule
bind tmc_timer tmc_timer_checker u_chk (.sys_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_dir_eff,
    .osc_amp_enable, .ccp_reset_trigger, .overflow_irq, .time_base,
    .time_base_valid);
`default_nettype wire

// *** verification/test_tmc_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_tmc_timer;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [1:0] port_direction = 2'h0;
    logic sleep_mode = 1'b0;
    logic ccp_reset_trigger = 1'b0;
    logic src_en = 1'b0;
    wire logic [7:0] reg_rdata;
    wire logic [1:0] pin_dir_eff;
    wire logic osc_amp_enable, overflow_irq, time_base_valid;
    wire logic [15:0] time_base;
    wire logic ext_clock_pin, osc_input_pin;
    logic [31:0] seed = 32'd81663;
    logic [31:0] r;
    logic [7:0] rv, a;
    logic [7:0] regs [6] = '{8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h8c, 8'h55};
    int error_cnt = 0;
    int checks_done = 0;
    int p, k;
    tmc_timer u_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .ext_clock_pin, .osc_input_pin,
        .port_direction, .pin_dir_eff, .osc_amp_enable, .sleep_mode,
        .ccp_reset_trigger, .overflow_irq, .time_base, .time_base_valid);
    tmc_ext_source u_src (.src_en, .ext_clock_pin, .osc_input_pin);
    always #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Five prescaled counts per window when running awake, none otherwise
    function automatic logic [15:0] ticks(int mode);
        return mode == 1 ? 16'h0005 : 16'h0000;
    endfunction
    task wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] ad);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #400us;
        error_cnt++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (regs[i]) begin
            rd(regs[i]);
            chk("reset value", rv, 16'h0000);
        end
        wr(8'h10, 8'hfe);
        rd(8'h10);
        chk("control", rv, 16'h003e);
        repeat (4) begin
            r = rnd();
            wr(8'h0e, r[7:0]);
            wr(8'h0f, r[15:8]);
            rd(8'h0e);
            chk("count low", rv, r[7:0]);
            rd(8'h0f);
            chk("count high", rv, r[15:8]);
        end
        $display("register test done");
        // Modes: stopped, running, running in sleep
        for (int m = 0; m < 12; m++) begin
            p = m % 4;
            r = rnd();
            sleep_mode <= m / 4 == 2;
            wr(8'h10, {2'b00, p[1:0], 1'b0, r[0], 1'b0, m / 4 != 0});
            // A new prescale tap may give one stray rise; let it pass
            repeat (4) @(posedge sys_clk);
            rd(8'h0e);
            a = rv;
            repeat ((20 << p) - 2) @(posedge sys_clk);
            rd(8'h0e);
            chk("timer rate", 8'(rv - a), ticks(m / 4));
        end
        sleep_mode <= 1'b0;
        $display("timer test done");
        for (int m = 0; m < 8; m++) begin
            p = m % 4;
            k = m / 4;
            r = rnd();
            port_direction <= r[1:0];
            wr(8'h10, {2'b00, p[1:0], k[0], 1'b0, 2'b11});
            wr(8'h0e, 8'h00);
            wr(8'h0f, 8'h00);
            chk("pin dir", pin_dir_eff, k ? 2'b11 : r[1:0]);
            chk("osc amp", osc_amp_enable, k[0]);
            chk("base valid", time_base_valid, 1'b1);
            src_en = 1'b1;
            repeat (3 << p) @(posedge (k ? osc_input_pin : ext_clock_pin));
            src_en = 1'b0;
            repeat (20) @(posedge sys_clk);
            rd(8'h0e);
            chk("edge count", rv, 16'h0003);
            chk("time base", time_base, 16'h0003);
        end
        $display("counter test done");
        for (int s = 0; s < 2; s++) begin
            wr(8'h10, {5'b00000, s[0], 2'b11});
            wr(8'h0e, 8'h00);
            wr(8'h0f, 8'h00);
            sleep_mode <= 1'b1;
            src_en = 1'b1;
            repeat (4) @(posedge ext_clock_pin);
            src_en = 1'b0;
            repeat (20) @(posedge sys_clk);
            sleep_mode <= 1'b0;
            rd(8'h0e);
            chk("sleep count", rv, s ? 16'h0004 : 16'h0000);
            chk("base valid", time_base_valid, s == 0);
        end
        $display("sleep test done");
        wr(8'h10, 8'h00);
        wr(8'h0f, 8'hff);
        wr(8'h0e, 8'hff);
        wr(8'h8c, 8'h01);
        ccp_reset_trigger <= 1'b1;
        @(posedge sys_clk);
        ccp_reset_trigger <= 1'b0;
        rd(8'h0f);
        chk("trigger clear", rv, 16'h0000);
        rd(8'h0c);
        chk("trigger flag", rv, 16'h0000);
        @(posedge sys_clk);
        reg_addr <= 8'h0e;
        reg_wdata <= 8'h5a;
        reg_wr <= 1'b1;
        ccp_reset_trigger <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        ccp_reset_trigger <= 1'b0;
        rd(8'h0e);
        chk("write wins", rv, 16'h005a);
        wr(8'h0f, 8'hff);
        wr(8'h0e, 8'hff);
        wr(8'h10, 8'h01);
        repeat (12) @(posedge sys_clk);
        rd(8'h0c);
        chk("overflow flag", rv, 16'h0001);
        chk("irq on", overflow_irq, 1'b1);
        wr(8'h8c, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk("irq masked", overflow_irq, 1'b0);
        rd(8'h0c);
        chk("flag kept", rv, 16'h0001);
        wr(8'h0c, 8'h00);
        rd(8'h0c);
        chk("flag cleared", rv, 16'h0000);
        $display("overflow test done");
        report_and_stop;
    end
endmodule
`default_nettype wire
